// >>> audio_path_map.vh
// Field positions, reset values and load constants for the audio path configuration registers
// Function
// (RULE_01) Mixer A select bits 10:9; 00 line input
// (RULE_02) Mixer A control bits 8:7, selects passed inputs
// (RULE_03) Secondary bit 4 picks filter source
// (RULE_04) Secondary bit 1 zero powers filter up
// (RULE_05) Bits 3:2 select 6.4/5.3/8.0 kHz rate
// (RULE_06) Mixer B control bits 6:5; 10 filter only
// (RULE_07) Secondary bit 0 zero powers mic preamp
// (RULE_08) Primary bit 9 zero selects mic preamp
// (RULE_09) Bits 15:14 select attenuator source, 01 mixer B
// (RULE_10) Primary bit 0 zero powers attenuator up
// (RULE_11) Bits 13:11 give attenuation level 0..7
// (RULE_12) Primary bits 4:3; 00 routes attenuator out
// (RULE_13) Primary bits 2:1 set output amplifier mode
// (RULE_14) Host reloads both when primary changes
// (RULE_15) Array record input always from mixer B
// (RULE_16) Primary before secondary; both apply together
// (RULE_17) Each register loads as two bytes
// (RULE_18) Whole register replaced; outputs never partial
`ifndef AUDIO_PATH_MAP_VH
`define AUDIO_PATH_MAP_VH

`define REG_WIDTH          16
`define BYTE_WIDTH         8
`define PRIMARY_RESET      16'h0001
`define SECONDARY_RESET    16'h0003

// Secondary register fields
`define SEC_PREAMP_PD      0
`define SEC_FILTER_PD      1
`define SEC_RATE_LO        2
`define SEC_RATE_HI        3
`define SEC_FILTER_SRC     4
`define SEC_MIXB_LO        5
`define SEC_MIXB_HI        6
`define SEC_MIXA_CTRL_LO   7
`define SEC_MIXA_CTRL_HI   8
`define SEC_MIXA_SEL_LO    9
`define SEC_MIXA_SEL_HI    10
`define SEC_LEVEL_LO       11
`define SEC_LEVEL_HI       13
`define SEC_ATTN_SRC_LO    14
`define SEC_ATTN_SRC_HI    15

// Primary register fields
`define PRI_ATTN_PD        0
`define PRI_AMP_LO         1
`define PRI_AMP_HI         2
`define PRI_OUTMUX_LO      3
`define PRI_OUTMUX_HI      4
`define PRI_INPUT_SRC      9

// Encodings
`define RATE_8K0           2'h0
`define RATE_6K4           2'h1
`define RATE_5K3           2'h2
`define MIXA_SEL_LINE      2'h0
`define MIXB_FILTER_ONLY   2'h2
`define ATTN_SRC_MIXB      2'h1
`define OUTMUX_ATTN        2'h0
`define AMP_SPK_HIGH       2'h1

`endif

// >>> cfg_byte_assembler.v
// Assembles two host bytes into one 16-bit configuration word
`timescale 1ns/10ps
`include "audio_path_map.vh"
module cfg_byte_assembler #(
  parameter WORD_WIDTH = 16
) (
  input  wire                  clk,        // System clock
  input  wire                  rst_b,      // Async reset, active low
  input  wire                  clkEn,      // Clock enable
  input  wire                  byteValid,  // Byte strobe
  input  wire [7:0]            byteData,   // Byte, high byte first
  input  wire                  frameStart, // Restart pairing
  output reg                   wordValid,  // One-cycle word done
  output reg  [WORD_WIDTH-1:0] wordData    // Assembled word
);

  reg       haveHigh_q;
  reg [7:0] highByte_q;

  // High byte held until its partner arrives; a lone byte never leaks out
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      haveHigh_q <= 1'b0;
      highByte_q <= 8'h00;
      wordValid  <= 1'b0;
      wordData   <= {WORD_WIDTH{1'b0}};
    end else if (clkEn) begin
      wordValid <= 1'b0;
      if (frameStart) begin
        haveHigh_q <= 1'b0;
      end else if (byteValid) begin
        if (!haveHigh_q) begin
          highByte_q <= byteData;
          haveHigh_q <= 1'b1;
        end else begin
          wordData   <= {highByte_q, byteData}; // RULE_17
          wordValid  <= 1'b1;
          haveHigh_q <= 1'b0;
        end
      end
    end
  end

endmodule

// >>> audio_path_config_regs.v
// Audio path configuration registers with shadow load and field decode
`timescale 1ns/10ps
`include "audio_path_map.vh"
module audio_path_config_regs (
  input  wire        clk,             // System clock, 100 MHz
  input  wire        rst_b,           // Async reset, active low
  input  wire        clkEn,           // Freezes all state when low
  input  wire        frameStart,      // Start of a register load
  input  wire        byteValid,       // Host byte strobe
  input  wire [7:0]  byteData,        // Host byte, high byte first
  input  wire        loadBoth,        // Frame loads primary then secondary
  input  wire        serialClkRise,   // Rising serial clock edge, apply point
  output reg  [15:0] primaryRead,     // Active primary register
  output reg  [15:0] secondaryRead,   // Active secondary register
  output reg  [1:0]  mixerASel,       // Mixer A input mux
  output reg         mixerALineSel,   // Line input routed to mixer A
  output reg         mixerAPassMux,   // Mixer A passes its mux input
  output reg         mixerAPassSrc,   // Mixer A passes input source
  output reg         filterFromArray, // Filter mux picks array output
  output reg         filterPowerUp,   // Low-pass filter powered
  output reg  [1:0]  rateSel,         // Raw sample rate code
  output reg         rate8k0,         // 8.0 kHz selected
  output reg         rate6k4,         // 6.4 kHz selected
  output reg         rate5k3,         // 5.3 kHz selected
  output reg         mixerBFilterOnly,// Mixer B passes filter only
  output reg  [1:0]  mixerBCtrl,      // Mixer B control field
  output reg         preampPowerUp,   // Mic preamp powered
  output reg         inputFromPreamp, // Input source is mic preamp
  output reg         attnFromMixerB,  // Attenuator fed by mixer B
  output reg  [1:0]  attnSrcSel,      // Attenuator source field
  output reg         attnPowerUp,     // Attenuator powered
  output reg  [2:0]  attnLevel,       // Attenuation step 0..7
  output reg         outFromAttn,     // Output stage fed by attenuator
  output reg  [1:0]  outMuxSel,       // Output mux field
  output reg         speakerHighGain, // Speaker on, high gain
  output reg         auxOutPowerUp,   // Aux output powered
  output reg         recordFromMixerB // Array record input source
);

  wire        wordValid;
  wire [15:0] wordData;
  reg  [15:0] priShadow_q;
  reg  [15:0] secShadow_q;
  reg  [15:0] primary_q;
  reg  [15:0] secondary_q;
  reg         expectPri_q;
  reg         pending_q;
  reg         inFrame_q;
  wire        secDone;
  wire        applyNow;
  reg  [15:0] priNext;
  reg  [15:0] secNext;

  // Byte pairing into whole words
  cfg_byte_assembler #(
    .WORD_WIDTH (`REG_WIDTH)
  ) uAssembler (
    .clk        (clk),
    .rst_b      (rst_b),
    .clkEn      (clkEn),
    .byteValid  (byteValid),
    .byteData   (byteData),
    .frameStart (frameStart),
    .wordValid  (wordValid),
    .wordData   (wordData)
  );

  // Qualified events; an apply waits while a frame is still being loaded
  assign secDone  = ~frameStart & wordValid & ~expectPri_q;
  assign applyNow = pending_q & serialClkRise & ~inFrame_q; // RULE_18

  // Shadow loading; first word of a two-register frame is the primary
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      priShadow_q <= `PRIMARY_RESET;
      secShadow_q <= `SECONDARY_RESET;
      expectPri_q <= 1'b0;
    end else if (clkEn) begin
      if (frameStart) begin
        expectPri_q <= loadBoth; // RULE_16
      end else if (wordValid) begin
        if (expectPri_q) begin
          priShadow_q <= wordData; // RULE_18
          expectPri_q <= 1'b0;
        end else begin
          secShadow_q <= wordData; // RULE_18
        end
      end
    end
  end

  // Frame tracking; a half-loaded pair must never reach the active words
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      inFrame_q <= 1'b0;
    end else if (clkEn) begin
      if (frameStart) begin
        inFrame_q <= 1'b1;
      end else if (secDone) begin
        inFrame_q <= 1'b0;
      end
    end
  end

  // Pending apply; a new secondary word wins over an apply in the same cycle
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pending_q <= 1'b0;
    end else if (clkEn) begin
      if (secDone) begin
        pending_q <= 1'b1; // RULE_14
      end else if (applyNow) begin
        pending_q <= 1'b0;
      end
    end
  end

  // Active registers swap together only after the secondary completes
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      primary_q   <= `PRIMARY_RESET;
      secondary_q <= `SECONDARY_RESET;
    end else if (clkEn && applyNow) begin
      primary_q   <= priShadow_q; // RULE_16
      secondary_q <= secShadow_q; // RULE_16
    end
  end

  // Next active values so decoded outputs stay flops and stay aligned
  always @* begin
    priNext = primary_q;
    secNext = secondary_q;
    if (applyNow) begin
      priNext = priShadow_q;
      secNext = secShadow_q;
    end
  end

  // Read-back words follow the active words on the same edge
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      primaryRead   <= `PRIMARY_RESET;
      secondaryRead <= `SECONDARY_RESET;
    end else if (clkEn) begin
      primaryRead   <= priNext; // RULE_16
      secondaryRead <= secNext; // RULE_16
    end
  end

  // Mixer A input select and pass control
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mixerASel     <= 2'h0;
      mixerALineSel <= 1'b0;
      mixerAPassMux <= 1'b0;
      mixerAPassSrc <= 1'b0;
    end else if (clkEn) begin
      mixerASel     <= secNext[`SEC_MIXA_SEL_HI:`SEC_MIXA_SEL_LO];                    // RULE_01
      mixerALineSel <= (secNext[`SEC_MIXA_SEL_HI:`SEC_MIXA_SEL_LO] == `MIXA_SEL_LINE); // RULE_01
      mixerAPassMux <= secNext[`SEC_MIXA_CTRL_LO] & ~secNext[`SEC_MIXA_CTRL_HI];       // RULE_02
      mixerAPassSrc <= ~secNext[`SEC_MIXA_CTRL_LO] & secNext[`SEC_MIXA_CTRL_HI];       // RULE_02
    end
  end

  // Filter source, filter power and sample rate
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      filterFromArray <= 1'b0;
      filterPowerUp   <= 1'b0;
      rateSel         <= 2'h0;
      rate8k0         <= 1'b0;
      rate6k4         <= 1'b0;
      rate5k3         <= 1'b0;
    end else if (clkEn) begin
      filterFromArray <= secNext[`SEC_FILTER_SRC];                          // RULE_03
      filterPowerUp   <= ~secNext[`SEC_FILTER_PD];                          // RULE_04
      rateSel         <= secNext[`SEC_RATE_HI:`SEC_RATE_LO];                // RULE_05
      rate8k0         <= (secNext[`SEC_RATE_HI:`SEC_RATE_LO] == `RATE_8K0); // RULE_05
      rate6k4         <= (secNext[`SEC_RATE_HI:`SEC_RATE_LO] == `RATE_6K4); // RULE_05
      rate5k3         <= (secNext[`SEC_RATE_HI:`SEC_RATE_LO] == `RATE_5K3); // RULE_05
    end
  end

  // Mixer B control and microphone preamp power
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mixerBCtrl       <= 2'h0;
      mixerBFilterOnly <= 1'b0;
      preampPowerUp    <= 1'b0;
    end else if (clkEn) begin
      mixerBCtrl       <= secNext[`SEC_MIXB_HI:`SEC_MIXB_LO];                          // RULE_06
      mixerBFilterOnly <= (secNext[`SEC_MIXB_HI:`SEC_MIXB_LO] == `MIXB_FILTER_ONLY); // RULE_06
      preampPowerUp    <= ~secNext[`SEC_PREAMP_PD];                                    // RULE_07
    end
  end

  // Input source and volume attenuator
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      inputFromPreamp <= 1'b0;
      attnSrcSel      <= 2'h0;
      attnFromMixerB  <= 1'b0;
      attnPowerUp     <= 1'b0;
      attnLevel       <= 3'h0;
    end else if (clkEn) begin
      inputFromPreamp <= ~priNext[`PRI_INPUT_SRC];                                       // RULE_08
      attnSrcSel      <= secNext[`SEC_ATTN_SRC_HI:`SEC_ATTN_SRC_LO];                     // RULE_09
      attnFromMixerB  <= (secNext[`SEC_ATTN_SRC_HI:`SEC_ATTN_SRC_LO] == `ATTN_SRC_MIXB); // RULE_09
      attnPowerUp     <= ~priNext[`PRI_ATTN_PD];                                         // RULE_10
      attnLevel       <= secNext[`SEC_LEVEL_HI:`SEC_LEVEL_LO];                           // RULE_11
    end
  end

  // Output mux and amplifiers; aux stays off in speaker high-gain mode
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      outMuxSel       <= 2'h0;
      outFromAttn     <= 1'b0;
      speakerHighGain <= 1'b0;
      auxOutPowerUp   <= 1'b0;
    end else if (clkEn) begin
      outMuxSel       <= priNext[`PRI_OUTMUX_HI:`PRI_OUTMUX_LO];                   // RULE_12
      outFromAttn     <= (priNext[`PRI_OUTMUX_HI:`PRI_OUTMUX_LO] == `OUTMUX_ATTN); // RULE_12
      speakerHighGain <= (priNext[`PRI_AMP_HI:`PRI_AMP_LO] == `AMP_SPK_HIGH);      // RULE_13
      auxOutPowerUp   <= priNext[`PRI_AMP_HI];                                     // RULE_13
    end
  end

  // Record input is fixed; kept as a flop so every output is registered
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      recordFromMixerB <= 1'b1; // RULE_15
    end else if (clkEn) begin
      recordFromMixerB <= 1'b1; // RULE_15
    end
  end

endmodule

// >>> cfg_regs_chk_sva.sv
// Checker for configuration decode and apply timing
`timescale 1ns/10ps
module cfg_regs_chk (
  input wire        clk,              // System clock
  input wire        rst_b,            // Async reset, active low
  input wire        serialClkRise,    // Apply edge
  input wire [15:0] primaryRead,      // Active primary word
  input wire [15:0] secondaryRead,    // Active secondary word
  input wire [2:0]  attnLevel,        // Volume step
  input wire        mixerALineSel,    // Line input to mixer A
  input wire        mixerAPassMux,    // Mixer A passes its mux
  input wire        filterFromArray,  // Filter fed by array
  input wire        filterPowerUp,    // Filter powered
  input wire        rate6k4,          // 6.4 kHz rate
  input wire        mixerBFilterOnly, // Mixer B filter only
  input wire        preampPowerUp,    // Preamp powered
  input wire        inputFromPreamp,  // Input source is preamp
  input wire        attnFromMixerB,   // Attenuator fed by mixer B
  input wire        attnPowerUp,      // Attenuator powered
  input wire        outFromAttn,      // Output from attenuator
  input wire        speakerHighGain,  // Speaker high gain
  input wire        recordFromMixerB  // Record source
);
  reg         warm_q; // Decodes lag reset release by one edge
  wire [15:0] s = secondaryRead;
  wire [15:0] p = primaryRead;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) warm_q <= 1'b0;
    else warm_q <= 1'b1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  line_sel_a: assert property (warm_q |-> mixerALineSel == (s[10:9] == 2'h0)) else $error("line sel");
  mixa_ctrl_a: assert property (warm_q |-> mixerAPassMux == (s[7] & ~s[8])) else $error("mixer a");
  filter_cfg_a: assert property (warm_q |-> filterFromArray == s[4] && filterPowerUp == !s[1])
    else $error("filter");
  rate_six_a: assert property (warm_q |-> rate6k4 == (s[3:2] == 2'h1)) else $error("rate");
  mixb_pre_a: assert property (warm_q |-> mixerBFilterOnly == (s[6:5] == 2'h2) && preampPowerUp == !s[0])
    else $error("mixer b");
  in_src_a: assert property (warm_q |-> inputFromPreamp == !p[9]) else $error("input src");
  attn_cfg_a: assert property (warm_q |-> attnFromMixerB == (s[15:14] == 2'h1) && attnLevel == s[13:11])
    else $error("attn cfg");
  attn_pwr_a: assert property (warm_q |-> attnPowerUp == !p[0]) else $error("attn pwr");
  out_path_a: assert property (warm_q |-> outFromAttn == (p[4:3] == 2'h0) && speakerHighGain == (p[2:1] == 2'h1))
    else $error("out path");
  record_src_a: assert property (recordFromMixerB) else $error("record src");
  apply_time_a: assert property (warm_q && (p != $past(p) || s != $past(s)) |->
    $past(serialClkRise) || $past(serialClkRise, 2)) else $error("early apply");
  cover property (serialClkRise);
  cover property (attnFromMixerB && attnPowerUp);
  cover property (rate6k4 && mixerALineSel);
endmodule
bind audio_path_config_regs cfg_regs_chk chk (.*);

// >>> host_link_model.sv
// Host side model that frames configuration loads
`timescale 1ns/10ps
module host_link_model (
  input  wire      clk,          // System clock
  output reg       frameStart,   // Frame start pulse
  output reg       byteValid,    // Byte strobe
  output reg [7:0] byteData,     // Byte value
  output reg       loadBoth,     // Frame holds both words
  output reg       serialClkRise // Apply edge
);
  initial {frameStart, byteValid, byteData, loadBoth, serialClkRise} = 12'h0a4;
  // Held until sampled; back to back bytes keep the strobe up
  task put(input [7:0] b);
    begin
      byteData = b;
      byteValid = 1'b1;
      @(posedge clk) #1;
    end
  endtask
  task load(input both, input [15:0] pw, input [15:0] sw);
    begin
      frameStart = 1'b1;
      loadBoth = both;
      @(posedge clk) #1;
      frameStart = 1'b0;
      if (both) put(pw[15:8]);
      if (both) put(pw[7:0]);
      put(sw[15:8]);
      put(sw[7:0]);
      byteValid = 1'b0;
      byteData = ~byteData; // Released bus does not keep the old byte
      repeat (3) @(posedge clk) #1;
    end
  endtask
  task apply;
    begin
      serialClkRise = 1'b1;
      @(posedge clk) #1;
      serialClkRise = 1'b0;
    end
  endtask
endmodule

// >>> test_audio_path_config_regs.sv
// Testbench for the audio path configuration registers
`timescale 1ns/10ps
module test_audio_path_config_regs;
  reg         clk = 1'b0, rst_b = 1'b0;
  reg         clkEn = 1'b1;
  wire [1:0]  mixerASel, rateSel, mixerBCtrl, attnSrcSel, outMuxSel;
  wire [9:0]  raw = {mixerASel, rateSel, mixerBCtrl, attnSrcSel, outMuxSel};
  wire [15:0] primaryRead, secondaryRead;
  wire [7:0]  byteData;
  wire [2:0]  attnLevel;
  wire        frameStart, byteValid, loadBoth, serialClkRise, mixerALineSel, mixerAPassMux, mixerAPassSrc;
  wire        filterFromArray, filterPowerUp, rate8k0, rate6k4, rate5k3, mixerBFilterOnly, preampPowerUp;
  wire        inputFromPreamp, attnFromMixerB, attnPowerUp, outFromAttn, speakerHighGain, auxOutPowerUp;
  wire        recordFromMixerB;
  wire [15:0] dec = {mixerALineSel, mixerAPassMux, mixerAPassSrc, filterFromArray, filterPowerUp, rate8k0,
    rate6k4, rate5k3, mixerBFilterOnly, preampPowerUp, inputFromPreamp, attnFromMixerB, attnPowerUp,
    outFromAttn, speakerHighGain, auxOutPowerUp};
  integer     mismatches = 0, samples_checked = 0, i;
  audio_path_config_regs uut (.*);
  host_link_model host (.*);
  always #5 clk = ~clk;
  // Expected decode, bit for bit in the order of dec
  function [15:0] want(input [15:0] p, input [15:0] s);
    want = {s[10:9] == 2'h0, s[7] & ~s[8], ~s[7] & s[8], s[4], ~s[1], s[3:2] == 2'h0, s[3:2] == 2'h1,
      s[3:2] == 2'h2, s[6:5] == 2'h2, ~s[0], ~p[9], s[15:14] == 2'h1, ~p[0], p[4:3] == 2'h0,
      p[2:1] == 2'h1, p[2]};
  endfunction
  // Expected raw fields, in the order of raw
  function [9:0] fields(input [15:0] p, input [15:0] s);
    fields = {s[10:9], s[3:2], s[6:5], s[15:14], p[4:3]};
  endfunction
  task check(input string what, input [15:0] seen, input [15:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task conclude;
    begin
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  task rcheck;
    begin
      check("reset pri", primaryRead, 16'h0001);
      check("reset sec", secondaryRead, 16'h0003);
      check("reset decode", dec, want(16'h0001, 16'h0003));
      check("reset fields", raw, fields(16'h0001, 16'h0003));
      $display("reset test done");
    end
  endtask
  // Load, confirm the read words hold before the apply edge, then compare
  task run(input both, input [15:0] p, input [15:0] s);
    reg [15:0] p0, s0;
    begin
      p0 = primaryRead;
      s0 = secondaryRead;
      host.load(both, p, s);
      check("held pri", primaryRead, p0);
      check("held sec", secondaryRead, s0);
      host.apply;
      @(posedge clk) #1;
      if (both) p0 = p;
      check("pri", primaryRead, p0);
      check("sec", secondaryRead, s);
      check("decode", dec, want(p0, s));
      check("level", attnLevel, s[13:11]);
      check("fields", raw, fields(p0, s));
      check("record", recordFromMixerB, 1'b1);
      $display("load test done %h %h", p0, s);
    end
  endtask
  // A frozen clock enable swallows an apply edge; the next apply lands
  task freeze(input [15:0] s);
    reg [15:0] s0;
    begin
      s0 = secondaryRead;
      host.load(1'b0, 16'h0000, s);
      clkEn = 1'b0;
      host.apply;
      @(posedge clk) #1;
      check("frozen sec", secondaryRead, s0);
      clkEn = 1'b1;
      host.apply;
      @(posedge clk) #1;
      check("thawed sec", secondaryRead, s);
      $display("freeze test done");
    end
  endtask
  initial begin
    repeat (12) @(posedge clk);
    #1 rst_b = 1'b1;
    @(posedge clk) #1;
    rcheck;
    run(1'b1, 16'h440b, 16'h01e3);
    run(1'b0, 16'h440b, 16'h00c5);
    run(1'b1, 16'h2421, 16'h0148);
    run(1'b1, 16'h2424, 16'h59d1);
    for (i = 0; i < 8; i = i + 1)
      run(1'b0, 16'h2424, 16'h41d1 | {2'h0, i[2:0], 7'h00, i[1:0], 2'h0});
    freeze(16'h59d1);
    rst_b = 1'b0;
    @(posedge clk) #1;
    rst_b = 1'b1;
    @(posedge clk) #1;
    rcheck;
    conclude;
  end
  // Whole run needs well under 3000 cycles
  initial begin
    #100000;
    mismatches = mismatches + 1;
    conclude;
  end
endmodule
